// ===== logic/sdi_pkg.sv
// ----------------------------------------------------------------------------
// What this block does
// - One display mode at a time: 3-wire or 4-wire serial; 8-bit and 16-bit parallel only hold the queue.
// - Once configured, all panel control and clock waveforms come from hardware.
// - Panel reset output is active low; high releases and enables the panel.
// - Command/data select low for command bytes, high for parameter or data.
// - Panel select is active low and asserted to address the panel.
// - Device always sources the serial clock; the panel never drives it.
// - 3-wire mode shares one bidirectional line for write and read data.
// - 4-wire mode writes on a dedicated output and reads on a dedicated input.
// - Each write cycle carries one 8-bit byte, most significant bit first.
// - Written serial data changes only on falling serial clock edges.
// - Select low and bit 7 shown before first rise; next bits on falls.
// - Eighth falling edge presents bit 0 and sets the command/data level.
// - Messages span single-byte cycles; select may rise between; line ignored then.
// - 3-wire read: send command, release data line by last bit's falling edge.
// - Read payload is 8, 24 or 32 bits, set by the issued command.
// - A PWM backlight output whose duty cycle sets LED brightness.
// - 4-wire read: command on output line, data returns on input line.
// ----------------------------------------------------------------------------
package sdi_pkg;

    // ------------------------------------------------------------------------
    // Modes and command words
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SDI_MODE_3W,
        SDI_MODE_4W,
        SDI_MODE_P8,
        SDI_MODE_P16
    } sdi_mode_t;

    typedef enum logic [1:0] {
        SDI_RD_8,
        SDI_RD_24,
        SDI_RD_32,
        SDI_RD_RSVD
    } sdi_rdlen_t;

    typedef struct packed {
        logic       is_read;
        logic       is_param;
        sdi_rdlen_t rd_len;
        logic [7:0] data;
    } sdi_cmd_t;

    localparam int SDI_CMD_W  = $bits(sdi_cmd_t);
    localparam int SDI_FIFO_D = 32;
    localparam int SDI_BL_W   = 8;

    // ------------------------------------------------------------------------
    // Timing, in ns, and derived cycle counts
    // ------------------------------------------------------------------------
    localparam int SDI_CLK_NS = 5;
    localparam int SDI_TCSS_NS = 40;
    localparam int SDI_TCSH_NS = 40;
    localparam int SDI_TWRH_NS = 40;
    localparam int SDI_TRDH_NS = 60;

    localparam logic [15:0] SDI_CSS_CYC   = 16'((SDI_TCSS_NS + SDI_CLK_NS - 1) / SDI_CLK_NS);
    localparam logic [15:0] SDI_CSH_CYC   = 16'((SDI_TCSH_NS + SDI_CLK_NS - 1) / SDI_CLK_NS);
    localparam logic [15:0] SDI_WRH_CYC   = 16'((SDI_TWRH_NS + SDI_CLK_NS - 1) / SDI_CLK_NS);
    localparam logic [15:0] SDI_RDH_CYC   = 16'((SDI_TRDH_NS + SDI_CLK_NS - 1) / SDI_CLK_NS);
    localparam logic [15:0] SDI_HALF_DFLT = 16'h0010;

    localparam logic [5:0] SDI_BYTE_BITS = 6'h08;
    localparam logic [5:0] SDI_BITS_8    = 6'h08;
    localparam logic [5:0] SDI_BITS_24   = 6'h18;
    localparam logic [5:0] SDI_BITS_32   = 6'h20;
    localparam logic [5:0] SDI_DC_FALL   = 6'h07;

    function automatic logic [5:0] sdi_rd_bits(input sdi_rdlen_t len);
        unique case (len)
            SDI_RD_24: sdi_rd_bits = SDI_BITS_24;
            SDI_RD_32: sdi_rd_bits = SDI_BITS_32;
            default:   sdi_rd_bits = SDI_BITS_8;
        endcase
    endfunction : sdi_rd_bits

endpackage : sdi_pkg

// ===== logic/sdi_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sdi_fifo
    import sdi_pkg::*;
#(
    parameter int WIDTH = SDI_CMD_W,
    parameter int DEPTH = SDI_FIFO_D
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
        logic                        full;
        logic                        empty;
        logic                        room;
    } sdi_fifo_st_t;

    sdi_fifo_st_t q_ff;
    sdi_fifo_st_t nxt_q;
    logic         push;
    logic         pop;

    assign push      = in_valid && !q_ff.full;
    assign pop       = out_ready && !q_ff.empty;
    // Kept as its own flop so the ready pin needs no gate
    assign in_ready  = q_ff.room;
    assign out_valid = !q_ff.empty;
    assign out_data  = q_ff.mem[q_ff.rd];

    always_comb begin
        nxt_q = q_ff;
        if (push) begin
            nxt_q.mem[q_ff.wr] = in_data;
            nxt_q.wr           = (q_ff.wr == AW'(DEPTH - 1)) ? '0 : q_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_q.rd = (q_ff.rd == AW'(DEPTH - 1)) ? '0 : q_ff.rd + 1'b1;
        end
        nxt_q.cnt   = q_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
        nxt_q.full  = (nxt_q.cnt == (AW+1)'(DEPTH));
        nxt_q.empty = (nxt_q.cnt == '0);
        nxt_q.room  = !nxt_q.full;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_ff       <= '0;
            q_ff.empty <= 1'b1;
            q_ff.room  <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end
endmodule : sdi_fifo
`default_nettype wire

// ===== logic/sdi_bl_pwm.sv
`timescale 1ns/10ps
`default_nettype none
module sdi_bl_pwm
    import sdi_pkg::*;
#(
    parameter int WIDTH = SDI_BL_W
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] duty,
    output var  logic             pwm_out
);
    typedef struct packed {
        logic [WIDTH-1:0] phase;
        logic             out;
    } sdi_pwm_st_t;

    sdi_pwm_st_t q_ff;
    sdi_pwm_st_t nxt_q;

    assign pwm_out = q_ff.out;

    // Duty of all ones still gives one low slot per period
    always_comb begin
        nxt_q       = q_ff;
        nxt_q.phase = q_ff.phase + 1'b1;
        nxt_q.out   = (q_ff.phase < duty);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end
endmodule : sdi_bl_pwm
`default_nettype wire

// ===== logic/sdi_serial_display.sv
`timescale 1ns/10ps
`default_nettype none
module sdi_serial_display
    import sdi_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Configuration
    input  wire sdi_mode_t           cfg_mode,
    input  wire logic [15:0]         cfg_clk_half,
    input  wire logic                panel_reset_req,
    input  wire logic [SDI_BL_W-1:0] bl_duty,
    // Command stream
    input  wire logic                cmd_valid,
    output var  logic                cmd_ready,
    input  wire sdi_cmd_t            cmd_word,
    // Read result and busy flag
    output logic                     rd_valid,
    output logic [31:0]              rd_data,
    output logic                     busy,
    // Panel pins
    output logic                     panel_reset_n,
    output logic                     panel_select_n,
    output logic                     panel_serial_clk,
    output logic                     panel_cmd_data_sel,
    output logic                     panel_serial_out,
    input  wire logic                panel_serial_in,
    input  wire logic                panel_serial_io_in,
    output logic                     panel_serial_io_out,
    output logic                     panel_serial_io_oe,
    output var  logic                backlight_pwm_out
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE,
        S_LEAD,
        S_LOW,
        S_HIGH,
        S_TAIL,
        S_GAP
    } sdi_state_t;

    typedef struct packed {
        sdi_state_t  st;
        logic [15:0] cnt;
        logic [15:0] half;
        logic [5:0]  falls;
        logic [5:0]  rises;
        logic [5:0]  total;
        logic [7:0]  tx;
        logic [31:0] rx;
        logic        is_read;
        logic        dc_req;
        logic        three_wire;

        // Two flops on each data input before anything reads it
        logic        si_meta;
        logic        si_sync;
        logic        io_meta;
        logic        io_sync;

        // Pin images, so each panel pin leaves a flop
        logic        rst_n;
        logic        cs_n;
        logic        sck;
        logic        dc;
        logic        sdo;
        logic        sio;
        logic        sio_oe;
        logic        rd_valid;
        logic [31:0] rd_data;
        logic        busy;
    } sdi_main_st_t;

    sdi_main_st_t q_ff;
    sdi_main_st_t nxt_q;
    sdi_cmd_t     fifo_word;
    logic         fifo_valid;
    logic         fifo_pop;
    logic         serial_mode;
    logic         tick;
    logic         rx_bit;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [15:0] clamp_half(input logic [15:0] req,
                                               input logic [15:0] lo);
        clamp_half = (req < lo) ? lo : req;
    endfunction : clamp_half

    function automatic logic [15:0] load_cnt(input logic [15:0] cycles);
        load_cnt = (cycles == 16'h0000) ? 16'h0000 : cycles - 16'h0001;
    endfunction : load_cnt

    // ------------------------------------------------------------------------
    // Command buffer and backlight
    // ------------------------------------------------------------------------
    // Parallel modes are not served here, so the queue only drains in serial modes
    assign serial_mode = (cfg_mode == SDI_MODE_3W) || (cfg_mode == SDI_MODE_4W);
    assign fifo_pop    = (q_ff.st == S_IDLE) && serial_mode;

    sdi_fifo #(
        .WIDTH (SDI_CMD_W),
        .DEPTH (SDI_FIFO_D)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (cmd_valid),
        .in_ready  (cmd_ready),
        .in_data   (cmd_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_word)
    );

    sdi_bl_pwm #(
        .WIDTH (SDI_BL_W)
    ) u_pwm (
        .clk_sys (clk_sys),
        .rst     (rst),
        .duty    (bl_duty),
        .pwm_out (backlight_pwm_out)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign rd_valid            = q_ff.rd_valid;
    assign rd_data             = q_ff.rd_data;
    assign busy                = q_ff.busy;
    assign panel_reset_n       = q_ff.rst_n;
    assign panel_select_n      = q_ff.cs_n;
    assign panel_serial_clk    = q_ff.sck;
    assign panel_cmd_data_sel  = q_ff.dc;
    assign panel_serial_out    = q_ff.sdo;
    assign panel_serial_io_out = q_ff.sio;
    assign panel_serial_io_oe  = q_ff.sio_oe;

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    // One down-counter times every phase, so one compare ends each of them
    assign tick   = (q_ff.cnt == 16'h0000);

    // Sync lag is far shorter than the settled low phase
    assign rx_bit = q_ff.three_wire ? q_ff.io_sync : q_ff.si_sync;

    always_comb begin
        nxt_q          = q_ff;
        nxt_q.si_meta  = panel_serial_in;
        nxt_q.si_sync  = q_ff.si_meta;
        nxt_q.io_meta  = panel_serial_io_in;
        nxt_q.io_sync  = q_ff.io_meta;
        nxt_q.rst_n    = !panel_reset_req;
        nxt_q.rd_valid = 1'b0;
        nxt_q.cnt      = load_cnt(q_ff.cnt);

        unique case (q_ff.st)
            S_IDLE: begin
                nxt_q.busy = 1'b0;
                if (fifo_pop && fifo_valid) begin
                    nxt_q.busy       = 1'b1;
                    nxt_q.tx         = fifo_word.data;
                    nxt_q.is_read    = fifo_word.is_read;
                    nxt_q.dc_req     = fifo_word.is_param;
                    nxt_q.three_wire = (cfg_mode == SDI_MODE_3W);

                    if (fifo_word.is_read) begin
                        // Read clock is held to the slower read limits
                        nxt_q.half  = clamp_half(cfg_clk_half, SDI_RDH_CYC);
                        nxt_q.total = SDI_BYTE_BITS + sdi_rd_bits(fifo_word.rd_len);
                    end else begin
                        nxt_q.half  = clamp_half(cfg_clk_half, SDI_WRH_CYC);
                        nxt_q.total = SDI_BYTE_BITS;
                    end

                    nxt_q.falls      = '0;
                    nxt_q.rises      = '0;
                    nxt_q.rx         = '0;
                    nxt_q.cs_n       = 1'b0;
                    nxt_q.cnt        = load_cnt(SDI_CSS_CYC);
                    nxt_q.st         = S_LEAD;
                end
            end

            S_LEAD: begin
                if (tick) begin
                    // First fall puts bit 7 out ahead of the first rise
                    nxt_q.sck   = 1'b0;
                    nxt_q.falls = q_ff.falls + 1'b1;
                    nxt_q.tx    = {q_ff.tx[6:0], 1'b0};
                    if (q_ff.three_wire) begin
                        nxt_q.sio    = q_ff.tx[7];
                        nxt_q.sio_oe = 1'b1;
                    end else begin
                        nxt_q.sdo = q_ff.tx[7];
                    end
                    nxt_q.cnt = load_cnt(q_ff.half);
                    nxt_q.st  = S_LOW;
                end
            end

            S_LOW: begin
                if (tick) begin
                    nxt_q.sck   = 1'b1;
                    nxt_q.rises = q_ff.rises + 1'b1;

                    // Rises past the command byte carry returned bits
                    if (q_ff.rises >= SDI_BYTE_BITS) begin
                        nxt_q.rx = {q_ff.rx[30:0], rx_bit};
                    end

                    if (q_ff.rises + 1'b1 == q_ff.total) begin
                        nxt_q.cnt = load_cnt(SDI_CSH_CYC);
                        nxt_q.st  = S_TAIL;
                    end else begin
                        nxt_q.cnt = load_cnt(q_ff.half);
                        nxt_q.st  = S_HIGH;
                    end
                end
            end

            S_HIGH: begin
                if (tick) begin
                    nxt_q.sck   = 1'b0;
                    nxt_q.falls = q_ff.falls + 1'b1;
                    if (q_ff.falls < SDI_BYTE_BITS) begin
                        nxt_q.tx = {q_ff.tx[6:0], 1'b0};
                        if (q_ff.three_wire) begin
                            nxt_q.sio = q_ff.tx[7];
                        end else begin
                            nxt_q.sdo = q_ff.tx[7];
                        end
                    end
                    if (q_ff.falls == SDI_DC_FALL) begin
                        nxt_q.dc = q_ff.dc_req;
                    end
                    // Line freed on the fall that ends the last command bit
                    if (q_ff.falls == SDI_BYTE_BITS) begin
                        nxt_q.sio_oe = 1'b0;
                    end
                    nxt_q.cnt = load_cnt(q_ff.half);
                    nxt_q.st  = S_LOW;
                end
            end

            S_TAIL: begin
                if (tick) begin
                    nxt_q.cs_n   = 1'b1;
                    nxt_q.sio_oe = 1'b0;
                    if (q_ff.is_read) begin
                        nxt_q.rd_valid = 1'b1;
                        nxt_q.rd_data  = q_ff.rx;
                    end
                    nxt_q.cnt = load_cnt(SDI_CSS_CYC);
                    nxt_q.st  = S_GAP;
                end
            end

            S_GAP: begin
                // Minimum deselect time before the next byte
                if (tick) begin
                    nxt_q.st = S_IDLE;
                end
            end

            // Spare state codes drop the panel and return to idle
            default: begin
                nxt_q.cs_n   = 1'b1;
                nxt_q.sck    = 1'b1;
                nxt_q.sio_oe = 1'b0;
                nxt_q.st     = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_ff      <= '0;
            q_ff.st   <= S_IDLE;
            q_ff.half <= SDI_HALF_DFLT;
            q_ff.cs_n <= 1'b1;
            q_ff.sck  <= 1'b1;
            q_ff.dc   <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

endmodule : sdi_serial_display
`default_nettype wire

// ===== testbench/sdi_panel_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdi_panel_model (
    input  wire logic        panel_select_n,
    input  wire logic        panel_serial_clk,
    input  wire logic        panel_cmd_data_sel,
    input  wire logic        wr_bit,
    input  wire logic        rd_en,
    input  wire logic [31:0] rd_payload,
    input  wire logic [5:0]  rd_bits,
    output var  logic        drv,
    output var  logic        dout,
    output var  logic [7:0]  cap_byte,
    output var  logic        cap_dc,
    output var  int          cap_cnt
);
    int         rises;
    int         falls;
    logic [7:0] sh;

    initial begin
        drv = 1'b0;
        dout = 1'b0;
        cap_cnt = 0;
    end

    always @(negedge panel_select_n) begin
        rises = 0;
        falls = 0;
    end

    // Line is ignored while deselected
    always @(posedge panel_serial_clk) begin
        if (!panel_select_n) begin
            rises++;
            if (rises <= 8) sh = {sh[6:0], wr_bit};
            if (rises == 8) begin
                cap_byte = sh;
                cap_dc = panel_cmd_data_sel;
                cap_cnt++;
            end
        end
    end

    always @(negedge panel_serial_clk) begin
        if (!panel_select_n) begin
            falls++;
            if (rd_en && falls >= 9 && falls < 9 + rd_bits) begin
                drv = 1'b1;
                dout = rd_payload[rd_bits - 1 - (falls - 9)];
            end
        end
    end

    // Released line shows the inverse, so a stale bit never passes
    always @(posedge panel_select_n) begin
        if (drv) dout = ~dout;
        drv = 1'b0;
    end
endmodule : sdi_panel_model
`default_nettype wire

// ===== testbench/sdi_serial_display_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sdi_checker
    import sdi_pkg::*;
(
    input wire logic      clk_sys,
    input wire logic      rst,
    input wire sdi_mode_t cfg_mode,
    input wire logic      panel_reset_req,
    input wire logic      rd_valid,
    input wire logic      busy,
    input wire logic      panel_reset_n,
    input wire logic      panel_select_n,
    input wire logic      panel_serial_clk,
    input wire logic      panel_cmd_data_sel,
    input wire logic      panel_serial_out,
    input wire logic      panel_serial_io_out,
    input wire logic      panel_serial_io_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_RESET_PIN: assert property (!rst |=> panel_reset_n == !$past(panel_reset_req))
        else $error("panel reset pin does not follow request");
    AST_DC_ON_FALL: assert property ($changed(panel_cmd_data_sel) |->
        $fell(panel_serial_clk) && !panel_select_n)
        else $error("command/data select moved off a falling clock");
    AST_SDO_ON_FALL: assert property (!panel_select_n && $changed(panel_serial_out)
        |-> $fell(panel_serial_clk))
        else $error("serial out moved off a falling clock");
    AST_IO_ON_FALL: assert property (panel_serial_io_oe && $past(panel_serial_io_oe)
        && $changed(panel_serial_io_out) |-> $fell(panel_serial_clk))
        else $error("shared line moved off a falling clock");
    AST_SELECT_SETUP: assert property ($fell(panel_select_n) |->
        panel_serial_clk [*8] ##1 !panel_serial_clk)
        else $error("first clock fall not eight cycles after select");
    AST_CLK_IDLE: assert property (panel_select_n |-> panel_serial_clk)
        else $error("serial clock not idle high while deselected");
    AST_LOW_WIDTH: assert property ($fell(panel_serial_clk) |-> !panel_serial_clk [*8])
        else $error("serial clock low phase too short");
    AST_HIGH_WIDTH: assert property ($rose(panel_serial_clk) && !panel_select_n
        |-> panel_serial_clk [*8])
        else $error("serial clock high phase too short");
    AST_RD_PULSE: assert property (rd_valid |-> $rose(panel_select_n) ##1 !rd_valid)
        else $error("read result not a single pulse at frame end");
    AST_BUSY_FRAME: assert property (!panel_select_n |-> busy)
        else $error("selected while not busy");
    AST_4W_NO_IO: assert property (cfg_mode == SDI_MODE_4W && panel_select_n
        |-> !panel_serial_io_oe)
        else $error("shared line driven in 4-wire mode");
endmodule : sdi_checker

bind sdi_serial_display sdi_checker u_chk (
    .clk_sys(clk_sys), .rst(rst), .cfg_mode(cfg_mode), .panel_reset_req(panel_reset_req),
    .rd_valid(rd_valid), .busy(busy), .panel_reset_n(panel_reset_n),
    .panel_select_n(panel_select_n), .panel_serial_clk(panel_serial_clk),
    .panel_cmd_data_sel(panel_cmd_data_sel), .panel_serial_out(panel_serial_out),
    .panel_serial_io_out(panel_serial_io_out), .panel_serial_io_oe(panel_serial_io_oe)
);
`default_nettype wire

// ===== testbench/serial_display_interface_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module serial_display_interface_bench
    import sdi_pkg::*;
;
    logic        clk_sys, rst, panel_reset_req, cmd_valid, cmd_ready, rd_valid, busy;
    logic        panel_reset_n, panel_select_n, panel_serial_clk, panel_cmd_data_sel;
    logic        panel_serial_out, io_in, io_out, io_oe, backlight_pwm_out, drv, dout;
    logic        cap_dc, rd_en;
    logic [15:0] cfg_clk_half;
    logic [7:0]  bl_duty, cap_byte;
    logic [31:0] rd_data, rd_payload;
    logic [5:0]  rd_bits;
    sdi_mode_t   cfg_mode;
    sdi_cmd_t    cmd_word;
    int          cap_cnt, num_errors, n_checks, cyc;

    // Shared line level from the device's enable alone; panel level otherwise
    assign io_in = io_oe ? io_out : dout;

    sdi_serial_display dut (
        .clk_sys(clk_sys), .rst(rst), .cfg_mode(cfg_mode), .cfg_clk_half(cfg_clk_half),
        .panel_reset_req(panel_reset_req), .bl_duty(bl_duty), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_word(cmd_word), .rd_valid(rd_valid), .rd_data(rd_data),
        .busy(busy), .panel_reset_n(panel_reset_n), .panel_select_n(panel_select_n),
        .panel_serial_clk(panel_serial_clk), .panel_cmd_data_sel(panel_cmd_data_sel),
        .panel_serial_out(panel_serial_out), .panel_serial_in(dout),
        .panel_serial_io_in(io_in), .panel_serial_io_out(io_out),
        .panel_serial_io_oe(io_oe), .backlight_pwm_out(backlight_pwm_out));

    sdi_panel_model panel (
        .panel_select_n(panel_select_n), .panel_serial_clk(panel_serial_clk),
        .panel_cmd_data_sel(panel_cmd_data_sel),
        .wr_bit(cfg_mode == SDI_MODE_4W ? panel_serial_out : io_in), .rd_en(rd_en),
        .rd_payload(rd_payload), .rd_bits(rd_bits), .drv(drv), .dout(dout),
        .cap_byte(cap_byte), .cap_dc(cap_dc), .cap_cnt(cap_cnt));

    task automatic report_and_stop;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic push(input sdi_cmd_t w);
        logic r;
        cmd_word = w;
        cmd_valid = 1'b1;
        do begin
            r = cmd_ready;
            @(posedge clk_sys);
            #1;
        end while (r !== 1'b1);
    endtask : push

    task automatic wait_cap(input int n);
        for (int i = 0; i < 2000 && cap_cnt < n; i++) @(posedge clk_sys);
        #1;
        `CHK("captured", 1'b1, cap_cnt >= n);
    endtask : wait_cap

    task automatic t_reset;
        `CHK("select", 1'b1, panel_select_n);
        `CHK("sclk", 1'b1, panel_serial_clk);
        `CHK("reset pin", 1'b0, panel_reset_n);
        `CHK("io oe", 1'b0, io_oe);
        `CHK("busy", 1'b0, busy);
        `CHK("ready", 1'b1, cmd_ready);
        rst = 1'b0;
        panel_reset_req = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 `CHK("reset pin", 1'b1, panel_reset_n);
    endtask : t_reset

    // Command then parameters back to back
    task automatic t_message(input sdi_mode_t m);
        int base;
        sdi_cmd_t w [3];
        w = '{12'h0A5, 12'h43C, 12'h481};
        cfg_mode = m;
        base = cap_cnt;
        foreach (w[k]) push(w[k]);
        cmd_valid = 1'b0;
        foreach (w[k]) begin
            wait_cap(base + k + 1);
            `CHK("byte", w[k].data, cap_byte);
            `CHK("cmd/data", w[k].is_param, cap_dc);
        end
    endtask : t_message

    task automatic t_read(input sdi_mode_t m, input sdi_rdlen_t len);
        int          bits;
        logic [31:0] exp_rd;
        bits = (len == SDI_RD_24) ? 24 : (len == SDI_RD_32) ? 32 : 8;
        exp_rd = bits == 32 ? rd_payload : rd_payload & ((32'h1 << bits) - 1);
        cfg_mode = m;
        rd_bits = 6'(bits);
        rd_en = 1'b1;
        push({1'b1, 1'b0, len, 8'h0A});
        cmd_valid = 1'b0;
        for (int i = 0; i < 3000 && rd_valid !== 1'b1; i++) @(posedge clk_sys) #1;
        `CHK("read done", 1'b1, rd_valid);
        `CHK("read cmd", 8'h0A, cap_byte);
        `CHK("read data", exp_rd, rd_data);
        rd_en = 1'b0;
    endtask : t_read

    // Parallel mode holds the queue; fill until refused, then drain serially
    task automatic t_fifo;
        int n;
        int base;
        logic r;
        while (busy !== 1'b0) @(posedge clk_sys) #1;
        cfg_mode = SDI_MODE_P8;
        n = 0;
        base = cap_cnt;
        cmd_valid = 1'b1;
        repeat (36) begin
            cmd_word = {4'h4, 8'(n)};
            r = cmd_ready;
            @(posedge clk_sys);
            #1;
            if (r === 1'b1) n++;
        end
        cmd_valid = 1'b0;
        // The wider parallel mode must hold the queue as well
        cfg_mode = SDI_MODE_P16;
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK("queued", 32, n);
        `CHK("select", 1'b1, panel_select_n);
        cfg_mode = SDI_MODE_4W;
        for (int k = 0; k < 32; k++) begin
            wait_cap(base + k + 1);
            `CHK("drain byte", 8'(k), cap_byte);
        end
    endtask : t_fifo

    task automatic t_pwm(input logic [7:0] d);
        int n;
        bl_duty = d;
        repeat (256) @(posedge clk_sys);
        n = 0;
        repeat (256) begin
            @(posedge clk_sys);
            #1;
            if (backlight_pwm_out === 1'b1) n++;
        end
        `CHK("pwm high", int'(d), n);
    endtask : t_pwm

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (drv) `CHK("io contention", 1'b0, io_oe);
        if (cyc == 40000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        rst = 1'b1;
        cfg_mode = SDI_MODE_3W;
        cfg_clk_half = 16'h000C;
        panel_reset_req = 1'b1;
        bl_duty = 8'h00;
        cmd_valid = 1'b0;
        cmd_word = '0;
        rd_en = 1'b0;
        rd_bits = 6'h08;
        rd_payload = 32'hC3A55A3C;
        repeat (6) @(posedge clk_sys);
        #1 t_reset();
        t_message(SDI_MODE_3W);
        t_message(SDI_MODE_4W);
        for (int l = 0; l < 4; l++) begin
            t_read(SDI_MODE_3W, sdi_rdlen_t'(l));
            t_read(SDI_MODE_4W, sdi_rdlen_t'(l));
        end
        t_fifo();
        t_pwm(8'h40);
        t_pwm(8'h00);
        report_and_stop();
    end
endmodule : serial_display_interface_bench
`default_nettype wire
